/* common/ptsp_pkg.sv */
// Package: constants, register map and carrier types of the period timer / system clock PWM
//
// Function
// - Prescaler input is the system oscillator clock, not the instruction clock.
// - Prescale select decodes 00 to 1, 01 to 4, 10 to 8, 11 to 16.
// - Each prescaler output pulse advances the period count by one.
// - Count compared with limit continuously; on equality next increment returns count to 00h.
// - Match sets match flag, bit 1 of flags; bit 1 of enable gates it.
// - Count and limit fully read/write; reset loads count 00h, limit FFh.
// - Timer counts only while run bit 2 of control is one.
// - Prescaler counter cleared by count write, control write and any reset.
// - Writing the control register leaves the period count unchanged.
// - Pulse-width stage is PWM only, no capture or compare.
// - Pulse-width output is the converter system clock.
// - Programmed duty never altered cycle by cycle by this logic.
// - System clock logic supports stand-alone and frequency synchronization modes.
// - Stand-alone: PWM is the system clock at programmed frequency and duty.
// - Programmed duty bounds the primary drive on-time the loop may request.
// - PWM period is (limit+1) times oscillator period times prescale factor.
// - On wrap, count clears and staged duty copies to active; not before.
package ptsp_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_PERIOD_LIMIT = 12'h004;
    localparam logic [11:0] ADDR_PERIOD_COUNT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h010;
    localparam logic [11:0] ADDR_DUTY_STAGING = 12'h014;
    localparam logic [11:0] ADDR_DUTY_ACTIVE = 12'h018;
    localparam logic [11:0] ADDR_MODE = 12'h01C;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int RUN_BIT = 2;
    localparam int MATCH_BIT = 1;
    localparam int SYNC_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET = 8'h00;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ptsp_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ptsp_apb_rsp_t;

    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] period_limit;
        logic [7:0] period_count;
        logic [7:0] peripheral_irq_enable;
        logic [7:0] peripheral_irq_flags;
        logic [7:0] duty_staging;
        logic [7:0] duty_active;
        logic sync_mode;
        logic [3:0] prescale_cnt;
        logic sys_clk;
        logic sync_pulse;
        logic [2:0] sync_pin;
        ptsp_apb_rsp_t rsp;
    } ptsp_state_t;

endpackage

/* hw/ptsp_timer.sv */
// Period timer with prescaler, PWM system clock generator and APB register slave
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module ptsp_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire ptsp_pkg::ptsp_apb_req_t apb_req,
    output ptsp_pkg::ptsp_apb_rsp_t apb_rsp,
    input wire logic sync_clk_in,
    output logic sys_clk,
    output logic sync_clk_out,
    output logic [7:0] drive_on_duty,
    output logic irq
);
    import ptsp_pkg::*;

    ptsp_state_t state_reg;
    ptsp_state_t state_next;

    // ----------------------------------------
    // Prescale decode
    // ----------------------------------------
    function automatic logic [3:0] prescale_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: prescale_last = 4'h0;
            2'h1: prescale_last = 4'h3;
            2'h2: prescale_last = 4'h7;
            2'h3: prescale_last = 4'hF;
        endcase
    endfunction

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic tick;
    logic match;
    logic wrap;
    logic sync_edge;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic mapped;

    always_comb begin
        state_next = state_reg;
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable;
        // Write lands at the edge where the master sees pready high
        wr = access && state_reg.rsp.pready && apb_req.pwrite;
        rd = setup && !apb_req.pwrite;
        wbyte = apb_req.pwdata[7:0];
        mapped = 1'b1;
        rbyte = 8'h00;

        // ----------------------------------------
        // Prescaler, count and PWM
        // ----------------------------------------
        // Prescaler runs on the oscillator clock itself
        tick = 1'b0;
        if (state_reg.timer_control[RUN_BIT]) begin
            if (state_reg.prescale_cnt >= prescale_last(state_reg.timer_control[1:0])) begin
                state_next.prescale_cnt = 4'h0;
                tick = 1'b1;
            end else begin
                state_next.prescale_cnt = state_reg.prescale_cnt + 4'h1;
            end
        end
        match = state_reg.period_count == state_reg.period_limit;
        // Slave mode: incoming master clock rising edge also restarts period
        state_next.sync_pin = {state_reg.sync_pin[1:0], sync_clk_in};
        sync_edge = state_reg.sync_mode && (state_reg.sync_pin[2:1] == 2'b01);
        wrap = (tick && match) || sync_edge;
        if (wrap) begin
            state_next.period_count = COUNT_RESET;
            state_next.duty_active = state_reg.duty_staging;
        end else if (tick) begin
            state_next.period_count = state_reg.period_count + 8'h01;
        end
        if (match) begin
            state_next.peripheral_irq_flags[MATCH_BIT] = 1'b1;
        end
        // Period start raises clock unless staged duty is zero, duty match drops it
        if (wrap) begin
            state_next.sys_clk = state_reg.duty_staging != 8'h00;
        end else if (state_next.period_count == state_reg.duty_active) begin
            state_next.sys_clk = 1'b0;
        end

        // ----------------------------------------
        // APB slave, answers in the access cycle
        // ----------------------------------------
        unique case (apb_req.paddr)
            ADDR_TIMER_CONTROL: rbyte = {5'h00, state_reg.timer_control[2:0]};
            ADDR_PERIOD_LIMIT: rbyte = state_reg.period_limit;
            ADDR_PERIOD_COUNT: rbyte = state_reg.period_count;
            ADDR_IRQ_ENABLE: rbyte = state_reg.peripheral_irq_enable;
            ADDR_IRQ_FLAGS: rbyte = state_reg.peripheral_irq_flags;
            ADDR_DUTY_STAGING: rbyte = state_reg.duty_staging;
            ADDR_DUTY_ACTIVE: rbyte = state_reg.duty_active;
            ADDR_MODE: rbyte = {7'h00, state_reg.sync_mode};
            default: mapped = 1'b0;
        endcase
        state_next.rsp.pready = setup;
        state_next.rsp.pslverr = setup && !mapped;
        state_next.rsp.prdata = rd ? {24'h000000, rbyte} : 32'h00000000;
        if (wr) begin
            unique case (apb_req.paddr)
                ADDR_TIMER_CONTROL: begin
                    state_next.timer_control = {5'h00, wbyte[2:0]};
                    state_next.prescale_cnt = 4'h0;
                end
                ADDR_PERIOD_LIMIT: state_next.period_limit = wbyte;
                ADDR_PERIOD_COUNT: begin
                    state_next.period_count = wbyte;
                    state_next.prescale_cnt = 4'h0;
                end
                ADDR_IRQ_ENABLE: state_next.peripheral_irq_enable = wbyte;
                ADDR_IRQ_FLAGS: state_next.peripheral_irq_flags = wbyte | {6'h00, match, 1'b0};
                // Staged only; takes effect at next wrap
                ADDR_DUTY_STAGING: state_next.duty_staging = wbyte;
                ADDR_MODE: state_next.sync_mode = wbyte[SYNC_BIT];
                default: ;
            endcase
        end
        // Read of flags clears them, a same-cycle match wins
        if (rd && apb_req.paddr == ADDR_IRQ_FLAGS) begin
            state_next.peripheral_irq_flags = {6'h00, match, 1'b0};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg.timer_control <= CONTROL_RESET;
            state_reg.period_limit <= LIMIT_RESET;
            state_reg.period_count <= COUNT_RESET;
            state_reg.peripheral_irq_enable <= IRQ_RESET;
            state_reg.peripheral_irq_flags <= IRQ_RESET;
            state_reg.duty_staging <= DUTY_RESET;
            state_reg.duty_active <= DUTY_RESET;
            state_reg.sync_mode <= 1'b0;
            state_reg.prescale_cnt <= 4'h0;
            state_reg.sys_clk <= 1'b0;
            state_reg.sync_pulse <= 1'b0;
            state_reg.sync_pin <= 3'h0;
            state_reg.rsp <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign apb_rsp = state_reg.rsp;
    assign sys_clk = state_reg.sys_clk;
    assign sync_clk_out = state_reg.sys_clk;
    assign drive_on_duty = state_reg.duty_active;
    assign irq = |(state_reg.peripheral_irq_flags & state_reg.peripheral_irq_enable);

endmodule

/* verification/ptsp_timer_assertions.sv */
// Port checker for the period timer
`timescale 1ns/1ps
module ptsp_timer_assertions
    import ptsp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire ptsp_pkg::ptsp_apb_req_t apb_req,
    input wire ptsp_pkg::ptsp_apb_rsp_t apb_rsp,
    input wire logic sync_clk_in,
    input wire logic sys_clk,
    input wire logic sync_clk_out,
    input wire logic [7:0] drive_on_duty,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rdy; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_idle; !apb_req.psel |=> !apb_rsp.pready; endproperty
    a_idle: assert property (p_idle) else $error("stray ready");
    property p_slv; apb_rsp.pready && apb_req.paddr > 12'h01C |-> apb_rsp.pslverr; endproperty
    a_slv: assert property (p_slv) else $error("no error");
    property p_rd0; apb_rsp.pready && !apb_req.pwrite |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("upper bits");
    property p_err; apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error data");
    property p_duty; $changed(drive_on_duty) |-> sys_clk == (drive_on_duty != 8'h00); endproperty
    a_duty: assert property (p_duty) else $error("duty latch");
    property p_sync; $rose(sys_clk) |-> ##[0:1] sync_clk_out; endproperty
    a_sync: assert property (p_sync) else $error("clock copy");
    c_err: cover property (apb_rsp.pslverr);
    c_clk: cover property ($rose(sys_clk));
    c_irq: cover property ($rose(irq));
endmodule
bind ptsp_timer ptsp_timer_assertions u_chk(.clk(clk), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .sync_clk_in(sync_clk_in), .sys_clk(sys_clk),
    .sync_clk_out(sync_clk_out), .drive_on_duty(drive_on_duty), .irq(irq));

/* verification/ptsp_loop_model.sv */
// Analog loop model beside the system clock
`timescale 1ns/1ps
module ptsp_loop_model (
    input wire logic [7:0] drive_on_duty,
    output logic sync_clk,
    output logic [7:0] on_time
);
    localparam logic [7:0] DEMAND = 8'hC0;
    // Stand-alone, no master clock
    assign sync_clk = 1'b0;
    assign on_time = (DEMAND > drive_on_duty) ? drive_on_duty : DEMAND;
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the period timer
`timescale 1ns/1ps
module tb_top;
    import ptsp_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    ptsp_apb_req_t req = '0;
    ptsp_apb_rsp_t rsp;
    logic sync_in, sys_clk, irq;
    logic [7:0] duty;
    logic [31:0] r = 32'hC4A4D90A;
    logic [31:0] q[$];
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    time t0;
    always #50 clk = ~clk;
    ptsp_timer u_dut (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
        .sync_clk_in(sync_in), .sys_clk(sys_clk), .sync_clk_out(), .drive_on_duty(duty),
        .irq(irq));
    ptsp_loop_model u_loop (.drive_on_duty(duty), .sync_clk(sync_in), .on_time());
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic results;
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask
    // Read data checked against oldest note
    always @(posedge clk) begin
        if (rsp.pready === 1'b1 && !req.pwrite && q.size() > 0) begin
            chk(rsp.prdata, q.pop_front());
        end
        if (++cyc > 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_PERIOD_LIMIT, 8'hFF);
        rd(ADDR_PERIOD_COUNT, 8'h00);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        rd(12'h020, 8'h00);
        repeat (4) begin
            r = lfsr(r);
            apb(1'b1, ADDR_PERIOD_LIMIT, r[7:0]);
            apb(1'b1, ADDR_PERIOD_COUNT, r[15:8]);
            rd(ADDR_PERIOD_LIMIT, r[7:0]);
            rd(ADDR_PERIOD_COUNT, r[15:8]);
        end
        apb(1'b1, ADDR_TIMER_CONTROL, 8'h03);
        rd(ADDR_PERIOD_COUNT, r[15:8]);
        apb(1'b1, ADDR_PERIOD_LIMIT, 8'h03);
        apb(1'b1, ADDR_DUTY_STAGING, 8'h01);
        rd(ADDR_DUTY_ACTIVE, 8'h00);
        apb(1'b1, ADDR_IRQ_ENABLE, 8'h02);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_TIMER_CONTROL, {6'h01, i[1:0]});
            @(posedge sys_clk);
            t0 = $time;
            @(posedge sys_clk);
            chk(($time - t0) / 100, 4 * (i == 0 ? 1 : 4 << (i - 1)));
        end
        @(negedge clk);
        chk(irq, 1'b1);
        rd(ADDR_DUTY_ACTIVE, 8'h01);
        apb(1'b1, ADDR_TIMER_CONTROL, 8'h00);
        apb(1'b1, ADDR_PERIOD_COUNT, 8'h02);
        repeat (40) @(posedge clk);
        rd(ADDR_PERIOD_COUNT, 8'h02);
        rd(ADDR_IRQ_FLAGS, 8'h02);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        @(negedge clk);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_IRQ_FLAGS, 8'h02);
        @(negedge clk);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_ENABLE, 8'h00);
        @(negedge clk);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_MODE, 8'h01);
        rd(ADDR_MODE, 8'h01);
        apb(1'b1, ADDR_MODE, 8'h00);
        rd(ADDR_MODE, 8'h00);
        results();
    end
endmodule
